// ### rtl/tsmh_spawn_ctrl.sv
// tsmh_spawn_ctrl: host-side builder and sender of thread spawn messages
//
// How it works
// - each message is exactly one eight-doubleword register, sent as eight beats
// - a root thread's final message carries the release operation
// - child threads also finish with a release message for consistency
// - the requester-kind bit reflects root or child as software set it
// - a root batch sends exactly the programmed number of root-spawn messages
// - the ten-bit offset is split into first-return-handle and six-bit offset
// - child header dword 7 low 24 bits copy the parent's own sequence
// - child sequence is base plus macroblock position, order independent
// - dword 6 bits 31:24 pass through from software, never hardware-made
// - header dwords 0 to 5 come straight from software registers
// - descriptor bit 0: 0 release, 1 spawn; reserved bits are zero
// - a final message may never carry the spawn operation
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tsmh_spawn_ctrl #(
  parameter int unsigned DWS = tsmh_pkg::MSG_DWS
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        msg_ready,
  output logic             msg_valid,
  output logic [31:0]      msg_dw,
  output logic [2:0]       msg_dw_idx,
  output logic             msg_last,
  output logic [15:0]      msg_desc,
  output logic             msg_eot
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tsmh_reg_if regs ();
  tsmh_pkg::tsmh_state_e state_ff;
  tsmh_pkg::tsmh_state_e nxt_state;
  logic [6:0]  ctrl_ff;
  logic [7:0]  root_cnt_ff;
  logic [23:0] seq_base_ff;
  logic [23:0] mb_pos_ff;
  logic [23:0] own_seq_ff;
  logic [31:0] pay_ff [DWS];
  logic        err_ff;
  logic [15:0] sent_cnt_ff;
  logic [7:0]  left_ff;
  logic [15:0] desc_ff;
  logic        eot_ff;
  logic        hdr_ff;
  logic        roots_ff;
  logic [7:0]  root_sent_ff;
  logic        tx_done;
  logic [DWS*32-1:0] msg_pay;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_pay(input logic [7:0] a);
    return a[7:5] == tsmh_pkg::PAY_PAGE;
  endfunction
  function automatic logic [2:0] pay_idx(input logic [7:0] a);
    return a[4:2];
  endfunction

  tsmh_ahb_slave u_slave (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs.slave)
  );

  // ---------------------------------------------------------------
  // write decode; config is frozen while a message is in flight
  // ---------------------------------------------------------------
  wire        idle    = (state_ff == tsmh_pkg::ST_IDLE);
  wire [7:0]  wa      = regs.wr_addr;
  wire [31:0] wd      = regs.wr_data;
  wire        wr_ok   = regs.wr_en && idle;
  wire        go      = wr_ok && (wa == tsmh_pkg::OFS_CTRL) && wd[tsmh_pkg::CTRL_GO];
  wire        w_roots = wd[tsmh_pkg::CTRL_ROOTS];
  wire        w_final = wd[tsmh_pkg::CTRL_FINAL] && !w_roots;
  // a thread never ends on a spawn, so that order is refused
  wire        bad_final = w_final && (wd[tsmh_pkg::CTRL_OP] == tsmh_pkg::OP_SPAWN);
  wire        launch  = go && !bad_final && !(w_roots && root_cnt_ff == 8'h00);
  wire        err_clr = regs.wr_en && (wa == tsmh_pkg::OFS_STATUS) &&
                        wd[tsmh_pkg::CTRL_OP];
  wire        batch_end = (state_ff == tsmh_pkg::ST_WAIT) && tx_done &&
                          (left_ff == 8'h01);

  // descriptor: only the defined bits are set, reserved ones stay zero
  wire        d_op  = w_roots ? tsmh_pkg::OP_SPAWN : wd[tsmh_pkg::CTRL_OP];
  wire        d_res = w_roots ? tsmh_pkg::RES_ROOT : wd[tsmh_pkg::CTRL_RES];
  wire [15:0] nxt_desc = (16'(d_op) << tsmh_pkg::DESC_OP) |
                         (16'(wd[tsmh_pkg::CTRL_CHILD]) << tsmh_pkg::DESC_REQ) |
                         (16'(d_res) << tsmh_pkg::DESC_RES);

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff     <= 7'h00;
      root_cnt_ff <= 8'h00;
      seq_base_ff <= 24'h0;
      mb_pos_ff   <= 24'h0;
      own_seq_ff  <= 24'h0;
      for (int i = 0; i < DWS; i++) begin
        pay_ff[i] <= 32'h0;
      end
    end else if (wr_ok) begin
      case (wa)
        tsmh_pkg::OFS_CTRL:    ctrl_ff     <= {wd[6:1], 1'b0};
        tsmh_pkg::OFS_ROOTCNT: root_cnt_ff <= wd[7:0];
        tsmh_pkg::OFS_SEQBASE: seq_base_ff <= wd[23:0];
        tsmh_pkg::OFS_MBPOS:   mb_pos_ff   <= wd[23:0];
        tsmh_pkg::OFS_OWNSEQ:  own_seq_ff  <= wd[23:0];
        default: begin
          if (is_pay(wa)) begin
            pay_ff[pay_idx(wa)] <= wd;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // message sequencer: one message, or a batch of root spawns
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tsmh_pkg::ST_IDLE:  nxt_state = launch ? tsmh_pkg::ST_START : tsmh_pkg::ST_IDLE;
      tsmh_pkg::ST_START: nxt_state = tsmh_pkg::ST_WAIT;
      tsmh_pkg::ST_WAIT: begin
        if (tx_done) begin
          nxt_state = batch_end ? tsmh_pkg::ST_IDLE : tsmh_pkg::ST_START;
        end
      end
      default: nxt_state = tsmh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= tsmh_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // batch bookkeeping; a root batch sends exactly root_cnt spawns
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      left_ff      <= 8'h00;
      desc_ff      <= 16'h0;
      eot_ff       <= 1'b0;
      hdr_ff       <= 1'b0;
      roots_ff     <= 1'b0;
      root_sent_ff <= 8'h00;
    end else if (launch) begin
      left_ff      <= w_roots ? root_cnt_ff : 8'h01;
      desc_ff      <= nxt_desc;
      eot_ff       <= w_final;
      hdr_ff       <= wd[tsmh_pkg::CTRL_HDR];
      roots_ff     <= w_roots;
      root_sent_ff <= 8'h00;
    end else if (tx_done) begin
      left_ff      <= 8'(left_ff - 8'h01);
      root_sent_ff <= 8'(root_sent_ff + 8'h01);
    end
  end

  // status: set of the error wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      err_ff      <= 1'b0;
      sent_cnt_ff <= 16'h0;
    end else begin
      err_ff      <= (go && bad_final) || (err_ff && !err_clr);
      sent_cnt_ff <= tx_done ? 16'(sent_cnt_ff + 16'h1) : sent_cnt_ff;
    end
  end

  // ---------------------------------------------------------------
  // payload assembly with the optional child debug header
  // ---------------------------------------------------------------
  // sequence depends only on position, so completion order cannot skew it
  wire [23:0] child_seq = 24'(seq_base_ff + mb_pos_ff);
  genvar gi;
  generate
    for (gi = 0; gi < DWS; gi++) begin : g_pay
      if (gi == tsmh_pkg::DW_CSEQ) begin : g_cseq
        // debug byte belongs to the system routine, passed untouched
        assign msg_pay[gi*32 +: 32] = hdr_ff ? {pay_ff[gi][31:24], child_seq}
                                             : pay_ff[gi];
      end else if (gi == tsmh_pkg::DW_PSEQ) begin : g_pseq
        // snapshot bit is the dispatcher's, so the parent sends it clear
        assign msg_pay[gi*32 +: 32] = hdr_ff ? {1'b0, pay_ff[gi][30:24], own_seq_ff}
                                             : pay_ff[gi];
      end else begin : g_sw
        assign msg_pay[gi*32 +: 32] = pay_ff[gi];
      end
    end
  endgenerate

  tsmh_msg_tx #(
    .DWS (DWS),
    .IW  (tsmh_pkg::IDX_W)
  ) u_tx (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .start      (state_ff == tsmh_pkg::ST_START),
    .payload    (msg_pay),
    .desc       (desc_ff),
    .final_message_flag        (eot_ff),
    .msg_ready  (msg_ready),
    .done       (tx_done),
    .msg_valid  (msg_valid),
    .msg_dw     (msg_dw),
    .msg_dw_idx (msg_dw_idx),
    .msg_last   (msg_last),
    .msg_desc   (msg_desc),
    .msg_eot    (msg_eot)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0]  ra     = regs.rd_addr;
  wire [9:0]  handle = pay_ff[tsmh_pkg::DW_HANDLE][9:0];
  // write messages reach only six offset bits; the rest goes to the handle
  wire [31:0] split_w = {20'h0, 4'(handle >> tsmh_pkg::WOFS_W), 2'h0,
                         handle[tsmh_pkg::WOFS_W-1:0]};
  wire [31:0] stat_w  = {sent_cnt_ff, 14'h0, err_ff, !idle};
  assign regs.rd_data = is_pay(ra)                  ? pay_ff[pay_idx(ra)] :
                        (ra == tsmh_pkg::OFS_CTRL)    ? {25'h0, ctrl_ff} :
                        (ra == tsmh_pkg::OFS_STATUS)  ? stat_w :
                        (ra == tsmh_pkg::OFS_ROOTCNT) ? {24'h0, root_cnt_ff} :
                        (ra == tsmh_pkg::OFS_SEQBASE) ? {8'h0, seq_base_ff} :
                        (ra == tsmh_pkg::OFS_MBPOS)   ? {8'h0, mb_pos_ff} :
                        (ra == tsmh_pkg::OFS_OWNSEQ)  ? {8'h0, own_seq_ff} :
                        (ra == tsmh_pkg::OFS_SPLIT)   ? split_w : 32'h0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_BEAT_HOLD: assert property (
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_dw) && $stable(msg_dw_idx))
    else $error("beat changed while stalled");
  AST_LAST_IDX: assert property (
    msg_valid |-> (msg_last == (msg_dw_idx == 3'(DWS - 1))))
    else $error("last flag not on final doubleword");
  AST_FINAL_RELEASE: assert property (
    msg_valid && msg_eot |-> msg_desc[tsmh_pkg::DESC_OP] == tsmh_pkg::OP_RELEASE)
    else $error("final message without release");
  AST_NO_SPAWN_END: assert property (
    go && bad_final |=> idle && err_ff && !msg_valid)
    else $error("spawn accepted as final message");
  AST_DESC_RSVD: assert property (
    msg_valid |-> (msg_desc & 16'hffec) == 16'h0)
    else $error("reserved descriptor bits set");
  AST_REQ_KIND: assert property (
    launch |=> desc_ff[tsmh_pkg::DESC_REQ] == $past(wd[tsmh_pkg::CTRL_CHILD]))
    else $error("requester kind not as programmed");
  AST_ROOT_BATCH: assert property (
    batch_end && roots_ff |-> 8'(root_sent_ff + 8'h01) == root_cnt_ff)
    else $error("root spawn count mismatch");
  AST_PARENT_SEQ: assert property (
    msg_valid && hdr_ff && msg_dw_idx == 3'(tsmh_pkg::DW_PSEQ)
    |-> msg_dw[23:0] == own_seq_ff && !msg_dw[tsmh_pkg::SNAP_BIT])
    else $error("parent sequence not copied");
  AST_CHILD_SEQ: assert property (
    msg_valid && hdr_ff && msg_dw_idx == 3'(tsmh_pkg::DW_CSEQ)
    |-> msg_dw[23:0] == 24'(seq_base_ff + mb_pos_ff))
    else $error("child sequence wrong");
  AST_DBG_BYTE: assert property (
    msg_valid && msg_dw_idx == 3'(tsmh_pkg::DW_CSEQ)
    |-> msg_dw[31:24] == pay_ff[tsmh_pkg::DW_CSEQ][31:24])
    else $error("debug byte altered");
  AST_LAUNCH_SEND: assert property (
    launch |-> ##2 msg_valid && msg_dw_idx == 3'h0)
    else $error("message did not start");

  CVR_ROOT_BATCH: cover property (batch_end && roots_ff && root_cnt_ff > 8'h01);
  CVR_CHILD_END:  cover property (msg_valid && msg_eot && msg_desc[tsmh_pkg::DESC_REQ]);
  CVR_BAD_FINAL:  cover property (go && bad_final);
  CVR_STALL:      cover property (msg_valid && !msg_ready ##1 msg_valid && msg_ready);
endmodule
`default_nettype wire

// ### shared/tsmh_pkg.sv
// tsmh_pkg: constants and types shared by the spawn-message controller
package tsmh_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DW_W      = 32;
  localparam int unsigned MSG_DWS   = 8;
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned DESC_W    = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned SEQ_W     = 24;
  localparam int unsigned HANDLE_W  = 10;
  localparam int unsigned WOFS_W    = 6;
  localparam int unsigned RCNT_W    = 8;
  localparam int unsigned SENT_W    = 16;
  // ---------------------------------------------------------------
  // controller register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ROOTCNT = 8'h08;
  localparam logic [7:0] OFS_SEQBASE = 8'h0c;
  localparam logic [7:0] OFS_MBPOS   = 8'h10;
  localparam logic [7:0] OFS_OWNSEQ  = 8'h14;
  localparam logic [7:0] OFS_SPLIT   = 8'h18;
  localparam logic [2:0] PAY_PAGE    = 3'h1;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_GO    = 0;
  localparam int unsigned CTRL_OP    = 1;
  localparam int unsigned CTRL_CHILD = 2;
  localparam int unsigned CTRL_RES   = 3;
  localparam int unsigned CTRL_FINAL = 4;
  localparam int unsigned CTRL_HDR   = 5;
  localparam int unsigned CTRL_ROOTS = 6;
  localparam int unsigned DESC_OP    = 0;
  localparam int unsigned DESC_REQ   = 1;
  localparam int unsigned DESC_RES   = 4;
  localparam int unsigned DW_HANDLE  = 4;
  localparam int unsigned DW_CSEQ    = 6;
  localparam int unsigned DW_PSEQ    = 7;
  localparam int unsigned SNAP_BIT   = 31;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic OP_RELEASE = 1'b0;
  localparam logic OP_SPAWN   = 1'b1;
  localparam logic RES_ROOT   = 1'b1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_START = 3'h2,
    ST_WAIT  = 3'h4
  } tsmh_state_e;
endpackage

// ### shared/tsmh_reg_if.sv
// tsmh_reg_if: register access path between bus slave and core
`timescale 1ns/1ps
`default_nettype none
interface tsmh_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  modport slave (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
  modport core  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface
`default_nettype wire

// ### rtl/tsmh_ahb_slave.sv
// tsmh_ahb_slave: zero-wait AHB-Lite slave for the controller registers
`timescale 1ns/1ps
`default_nettype none
module tsmh_ahb_slave (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  tsmh_reg_if.slave        regs
);
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  wire        acc = hsel && hready && (htrans == tsmh_pkg::HTRANS_NONSEQ);

  // ---------------------------------------------------------------
  // address phase capture; read data registered for the data phase
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= tsmh_pkg::HRESP_OKAY;
    end else begin
      wr_pend_ff <= acc && hwrite;
      if (acc) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= regs.rd_data;
      end
      hreadyout <= 1'b1; // never stalls
      hresp     <= tsmh_pkg::HRESP_OKAY;
    end
  end

  // write lands at the end of the data phase, when hwdata stands
  assign regs.wr_en   = wr_pend_ff;
  assign regs.wr_addr = wr_addr_ff;
  assign regs.wr_data = hwdata;
  assign regs.rd_addr = haddr[7:0]; // upper address bits alias
endmodule
`default_nettype wire

// ### rtl/tsmh_msg_tx.sv
// tsmh_msg_tx: sends one message register as a burst of doubleword beats
`timescale 1ns/1ps
`default_nettype none
module tsmh_msg_tx #(
  parameter int unsigned DWS = tsmh_pkg::MSG_DWS,
  parameter int unsigned IW  = tsmh_pkg::IDX_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 start,
  input  wire logic [DWS*32-1:0]    payload,
  input  wire logic [15:0]          desc,
  input  wire logic                 final_message_flag,
  input  wire logic                 msg_ready,
  output logic                      done,
  output logic                      msg_valid,
  output logic [31:0]               msg_dw,
  output logic [IW-1:0]             msg_dw_idx,
  output logic                      msg_last,
  output logic [15:0]               msg_desc,
  output logic                      msg_eot
);
  localparam logic [IW-1:0] LAST_IDX = IW'(DWS - 1);
  wire          beat    = msg_valid && msg_ready;
  wire [IW-1:0] nxt_idx = msg_dw_idx + IW'(1);

  // ---------------------------------------------------------------
  // beat sequencer; descriptor and final flag stand the whole message
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done       <= 1'b0;
      msg_valid  <= 1'b0;
      msg_dw     <= 32'h0;
      msg_dw_idx <= '0;
      msg_last   <= 1'b0;
      msg_desc   <= 16'h0;
      msg_eot    <= 1'b0;
    end else begin
      done <= beat && msg_last;
      if (start && !msg_valid) begin
        msg_valid  <= 1'b1;
        msg_dw_idx <= '0;
        msg_dw     <= payload[31:0];
        msg_last   <= (LAST_IDX == '0);
        msg_desc   <= desc;
        msg_eot    <= final_message_flag;
      end else if (beat && msg_last) begin
        msg_valid <= 1'b0;
      end else if (beat) begin
        msg_dw_idx <= nxt_idx;
        msg_dw     <= payload[nxt_idx*32 +: 32];
        msg_last   <= (nxt_idx == LAST_IDX);
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tsmh_launcher_model.sv
// tsmh_launcher_model: behavioural thread launcher taking spawn messages
`timescale 1ns/1ps
`default_nettype none
module tsmh_launcher_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        msg_valid,
  input  wire logic [31:0] msg_dw,
  input  wire logic [2:0]  msg_dw_idx,
  input  wire logic        msg_last,
  input  wire logic [15:0] msg_desc,
  input  wire logic        msg_eot,
  output logic             msg_ready
);
  logic [31:0] dw [8];
  logic [15:0] ldesc;
  logic        leot;
  logic [7:0]  nmsg, nroot, nend, nbad;
  logic [2:0]  nexti;
  logic        tog;
  // slow mode stalls every other cycle, as a busy launcher would
  assign msg_ready = !slow || tog;
  // only bits 0, 1 and 4 are decoded; reserved bits never matter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {tog, nexti, nmsg, nroot, nend, nbad, leot, ldesc} <= '0;
    end else begin
      tog <= !tog;
      if (msg_valid && msg_ready) begin
        dw[msg_dw_idx] <= msg_dw;
        nexti          <= nexti + 3'h1;
        // one eight-doubleword register, beats in order
        if (msg_dw_idx !== nexti || msg_last !== (nexti == 3'h7)) nbad <= nbad + 8'h1;
        if (msg_last) begin
          nmsg  <= nmsg + 8'h1;
          ldesc <= msg_desc;
          leot  <= msg_eot;
          // one synchronized root dispatched per root spawn
          if (msg_desc[0] && msg_desc[4]) nroot <= nroot + 8'h1;
          // root end seen only from a release by a root requester
          if (!msg_desc[0] && !msg_desc[1]) nend <= nend + 8'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// testbench: register-level tests of the spawn-message controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys, sys_rst, hsel, hwrite, hreadyout, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, msg_dw, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, msg_dw_idx;
  logic        msg_ready, msg_valid, msg_last, msg_eot;
  logic [15:0] msg_desc;
  int          bad_count, compares;
  tsmh_spawn_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg_dw(msg_dw), .msg_dw_idx(msg_dw_idx), .msg_last(msg_last),
    .msg_desc(msg_desc), .msg_eot(msg_eot));
  tsmh_launcher_model i_lnch (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .msg_valid(msg_valid), .msg_dw(msg_dw), .msg_dw_idx(msg_dw_idx), .msg_last(msg_last),
    .msg_desc(msg_desc), .msg_eot(msg_eot), .msg_ready(msg_ready));
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsel   <= 1'b1;
    htrans <= tsmh_pkg::HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // launch, then poll busy; bounded so a stuck engine ends as a mismatch
  task automatic go(input logic [31:0] c);
    int n;
    ahb(1'b1, tsmh_pkg::OFS_CTRL, c);
    repeat (2) @(posedge clk_sys);
    n = 0;
    do begin ahb(1'b0, tsmh_pkg::OFS_STATUS, 32'h0); n++; end while (q[0] !== 1'b0 && n < 300);
    if (n >= 300) chk(q, 32'h0);
  endtask
  task automatic results();
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // watchdog: the tests need a few thousand cycles at most
  initial begin
    #100000;
    bad_count++;
    results();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
    hsize   = 3'h2;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    ahb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0); // unmapped reads zero
    chk({31'h0, hresp}, 32'h0); // slave always answers okay
    for (int i = 0; i < 8; i++) ahb(1'b1, 8'h20 + 8'(4 * i), 32'h01010101 * i);
    ahb(1'b1, 8'h30, 32'h000002c5);
    ahb(1'b1, 8'h38, 32'hab000000);
    ahb(1'b1, 8'h3c, 32'hff000000);
    ahb(1'b0, tsmh_pkg::OFS_SPLIT, 32'h0);
    chk(q, 32'h00000b05);
    ahb(1'b1, tsmh_pkg::OFS_SEQBASE, 32'h00000100);
    ahb(1'b1, tsmh_pkg::OFS_MBPOS, 32'h00000023);
    ahb(1'b1, tsmh_pkg::OFS_OWNSEQ, 32'h00123456);
    slow <= 1'b1;
    go(32'h27); // child spawn with debug header, stalled link
    for (int i = 0; i < 6; i++) chk(i_lnch.dw[i], i == 4 ? 32'h2c5 : 32'h01010101 * i);
    chk(i_lnch.dw[6], 32'hab000123);
    chk(i_lnch.dw[7], 32'h7f123456);
    chk({i_lnch.leot, i_lnch.ldesc}, 32'h00003);
    slow <= 1'b0;
    go(32'h07); // child spawn, header left to software
    chk(i_lnch.dw[6], 32'hab000000);
    go(32'h13); // final flag with spawn must be refused
    chk({q[1], 23'h0, i_lnch.nmsg}, 32'h80000002);
    ahb(1'b1, tsmh_pkg::OFS_STATUS, 32'h2);
    ahb(1'b0, tsmh_pkg::OFS_STATUS, 32'h0);
    chk({q[1], 31'h0}, 32'h0); // error cleared
    ahb(1'b1, tsmh_pkg::OFS_ROOTCNT, 32'h3);
    go(32'h41); // root batch of three
    chk({i_lnch.nroot, i_lnch.ldesc, 7'h0, i_lnch.leot}, 32'h03001100);
    chk(q[31:16], 32'h5); // five messages sent
    ahb(1'b0, tsmh_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h40); // go bit reads back as zero
    ahb(1'b1, tsmh_pkg::OFS_ROOTCNT, 32'h0);
    go(32'h41); // empty root batch sends nothing
    chk(i_lnch.nmsg, 32'h5);
    go(32'h11); // root termination, handle released
    chk({i_lnch.nend, 7'h0, i_lnch.leot, i_lnch.ldesc}, 32'h01010000);
    go(32'h1d); // child termination, handle kept
    chk({i_lnch.nend, 7'h0, i_lnch.leot, i_lnch.ldesc}, 32'h01010012);
    chk(i_lnch.nbad, 32'h0);
    results();
  end
endmodule
`default_nettype wire
